// ---- p3fs_port3_function_select.v ----
// port 3 function select: apb registers, per-pin muxing and peripheral routing
// Summary of operation
// [R01] pin 3.3: 00 gpio by direction, 01 timer external clock, 10 irq three input.
// [R02] pin 3.4: 00 gpio by direction, 01 timer channel c, 10 irq two input.
// [R03] pin 3.5: 00 gpio, 01 channel d, 10 key wakeup two, 11 comparator out.
// [R04] pin 3.7: 00 gpio, 01 converter trigger, 10 timer j pulse, 11 channel d.
// [R05] direction bit is ignored whenever a nonzero select field picks a peripheral.
// [R06] channel c pin direction follows the timer channel c configuration.
// [R07] channel d on pin 3.5 or 3.7, direction from timer channel d configuration.
// [R08] channel a drives compare waveform when permit 0, two-phase 1, io 001.
// [R09] software sets timer mode, then other registers, then output permits.
// [R10] comparator analog and reference inputs stay connected during gpio input.
`timescale 1ns/10ps
`include "p3fs_map.vh"
module p3fs_port3_function_select #(
  parameter ADDR_W = 12
) (
  input wire clk_sys_i,
  input wire sys_rst_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [ADDR_W-1:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  input wire [3:0] pin_i,
  output reg [3:0] pin_o,
  output reg [3:0] pin_oe_n_o,
  input wire [3:0] gpio_out_i,
  output reg [3:0] gpio_in_o,
  input wire timer_c_channel_a_wave_i,
  output reg timer_c_channel_a_pin_o,
  output reg timer_c_channel_a_pin_oe_n_o,
  input wire timer_c_channel_c_wave_i,
  output reg timer_c_channel_c_capture_o,
  input wire timer_c_channel_d_wave_i,
  output reg timer_c_channel_d_capture_o,
  output reg timer_c_external_clock_in_o,
  output reg external_irq_three_in_o,
  output reg external_irq_two_in_o,
  output reg key_wakeup_two_in_o,
  input wire comparator_three_out_i,
  output reg comparator_three_analog_en_o,
  output reg comparator_three_reference_en_o,
  output reg converter_start_trigger_in_o,
  input wire timer_j_pulse_out_i
);
  // pin order inside vectors: 0 = 3.3, 1 = 3.4, 2 = 3.5, 3 = 3.7
  reg [3:0] dir_q;
  reg [7:0] fsel_q;
  reg [8:0] tmr_q;
  reg [31:0] rdata_d;
  reg err_d;
  wire [3:0] gpin_w;
  wire [3:0] cell_pin_w;
  wire [3:0] cell_oe_n_w;
  wire access_w;
  wire done_w;
  wire chan_a_cmp_w;
  wire sel33_f1_w;
  wire sel33_f2_w;
  wire sel34_f1_w;
  wire sel34_f2_w;
  wire sel35_f1_w;
  wire sel35_f2_w;
  wire sel37_f1_w;
  wire sel37_f3_w;
  wire [3:0] fn_dir0_w;
  wire [3:0] fn_out0_w;
  wire [3:0] fn_dir1_w;
  wire [3:0] fn_out1_w;
  wire [3:0] fn_dir2_w;
  wire [3:0] fn_out2_w;
  wire [3:0] fn_dir3_w;
  wire [3:0] fn_out3_w;
  // decode of an offset match, shared by read and write paths
  function hit;
    input [ADDR_W-1:0] a;
    input [11:0] ofs;
    begin
      hit = (a == ofs[ADDR_W-1:0]);
    end
  endfunction
  // compare one two-bit select field against a function code
  function sel_is;
    input [1:0] fld;
    input [1:0] code;
    begin
      sel_is = (fld == code);
    end
  endfunction
  assign access_w = psel_i & penable_i & ~pready_o;
  // an access completes at the edge that sees pready high
  assign done_w = psel_i & penable_i & pready_o;
  // register writes take effect at the completing edge
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      dir_q <= `P3FS_DIR_RST;
      fsel_q <= `P3FS_FSEL_RST;
      tmr_q <= `P3FS_TMR_RST;
    end else if (done_w & pwrite_i) begin
      if (hit(paddr_i, `P3FS_DIR_OFS)) begin
        dir_q <= pwdata_i[3:0];
      end else if (hit(paddr_i, `P3FS_FSEL_OFS)) begin
        fsel_q <= pwdata_i[7:0];
      end else if (hit(paddr_i, `P3FS_TMR_OFS)) begin
        tmr_q <= pwdata_i[8:0]; // R09
      end
    end
  end
  always @* begin
    rdata_d = 32'h0000_0000;
    err_d = 1'b0;
    if (hit(paddr_i, `P3FS_DIR_OFS)) begin
      rdata_d[3:0] = dir_q;
    end else if (hit(paddr_i, `P3FS_FSEL_OFS)) begin
      rdata_d[7:0] = fsel_q;
    end else if (hit(paddr_i, `P3FS_TMR_OFS)) begin
      rdata_d[8:0] = tmr_q;
    end else if (hit(paddr_i, `P3FS_PIN_OFS)) begin
      rdata_d[3:0] = pin_i;
      err_d = pwrite_i;
    end else begin
      err_d = 1'b1;
    end
  end
  // one wait state: pready rises in the second access cycle
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else begin
      pready_o <= access_w;
      pslverr_o <= access_w & err_d;
      prdata_o <= (access_w & ~pwrite_i) ? rdata_d : 32'h0000_0000;
    end
  end
  // channel a compare output; edge-select bits deliberately unused
  assign chan_a_cmp_w = ~tmr_q[`P3FS_TMR_EA] & tmr_q[`P3FS_TMR_TWO_PHASE_PULSE_MODE_BIT] &
    (tmr_q[`P3FS_TMR_IOA_LO+2:`P3FS_TMR_IOA_LO] == `P3FS_IOA_COMPARE); // R08
  // per-pin function tables, indexed by select value (bit 0 unused at 00)
  assign fn_dir0_w = 4'h0; // R01
  assign fn_out0_w = 4'h0;
  assign fn_dir1_w = {1'b0, 1'b0, tmr_q[`P3FS_TMR_CDIR], 1'b0}; // R02 R06
  assign fn_out1_w = {1'b0, 1'b0, timer_c_channel_c_wave_i, 1'b0};
  assign fn_dir2_w = {1'b1, 1'b0, tmr_q[`P3FS_TMR_DDIR], 1'b0}; // R03 R07
  assign fn_out2_w = {comparator_three_out_i, 1'b0, timer_c_channel_d_wave_i, 1'b0};
  assign fn_dir3_w = {tmr_q[`P3FS_TMR_DDIR], 1'b1, 1'b0, 1'b0}; // R04 R07
  assign fn_out3_w = {timer_c_channel_d_wave_i, timer_j_pulse_out_i, 1'b0, 1'b0};
  // select decodes shared by the input routing
  assign sel33_f1_w = sel_is(fsel_q[`P3FS_FLD33], `P3FS_SEL_F1);
  assign sel33_f2_w = sel_is(fsel_q[`P3FS_FLD33], `P3FS_SEL_F2);
  assign sel34_f1_w = sel_is(fsel_q[`P3FS_FLD34], `P3FS_SEL_F1);
  assign sel34_f2_w = sel_is(fsel_q[`P3FS_FLD34], `P3FS_SEL_F2);
  assign sel35_f1_w = sel_is(fsel_q[`P3FS_FLD35], `P3FS_SEL_F1);
  assign sel35_f2_w = sel_is(fsel_q[`P3FS_FLD35], `P3FS_SEL_F2);
  assign sel37_f1_w = sel_is(fsel_q[`P3FS_FLD37], `P3FS_SEL_F1);
  assign sel37_f3_w = sel_is(fsel_q[`P3FS_FLD37], `P3FS_SEL_F3);
  p3fs_pin_cell u_cell33 (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .sel_i(fsel_q[`P3FS_FLD33]),
    .gpio_dir_i(dir_q[0]),
    .gpio_out_i(gpio_out_i[0]),
    .fn_dir_i(fn_dir0_w),
    .fn_out_i(fn_out0_w),
    .pin_o(cell_pin_w[0]),
    .pin_oe_n_o(cell_oe_n_w[0]),
    .is_gpio_in_o(gpin_w[0])
  );
  p3fs_pin_cell u_cell34 (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .sel_i(fsel_q[`P3FS_FLD34]),
    .gpio_dir_i(dir_q[1]),
    .gpio_out_i(gpio_out_i[1]),
    .fn_dir_i(fn_dir1_w),
    .fn_out_i(fn_out1_w),
    .pin_o(cell_pin_w[1]),
    .pin_oe_n_o(cell_oe_n_w[1]),
    .is_gpio_in_o(gpin_w[1])
  );
  p3fs_pin_cell u_cell35 (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .sel_i(fsel_q[`P3FS_FLD35]),
    .gpio_dir_i(dir_q[2]),
    .gpio_out_i(gpio_out_i[2]),
    .fn_dir_i(fn_dir2_w),
    .fn_out_i(fn_out2_w),
    .pin_o(cell_pin_w[2]),
    .pin_oe_n_o(cell_oe_n_w[2]),
    .is_gpio_in_o(gpin_w[2])
  );
  p3fs_pin_cell u_cell37 (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .sel_i(fsel_q[`P3FS_FLD37]),
    .gpio_dir_i(dir_q[3]),
    .gpio_out_i(gpio_out_i[3]),
    .fn_dir_i(fn_dir3_w),
    .fn_out_i(fn_out3_w),
    .pin_o(cell_pin_w[3]),
    .pin_oe_n_o(cell_oe_n_w[3]),
    .is_gpio_in_o(gpin_w[3])
  );
  // direction bit only consulted inside the cell at select 00
  always @* begin
    pin_o = cell_pin_w; // R05
    pin_oe_n_o = cell_oe_n_w;
  end
  // input routing to peripherals, registered; unselected inputs read 0
  // gpio input data is the plain pin level, whatever the function
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      gpio_in_o <= 4'h0;
    end else begin
      gpio_in_o <= pin_i;
    end
  end
  // timer external clock on pin 3.3
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      timer_c_external_clock_in_o <= 1'b0;
    end else begin
      timer_c_external_clock_in_o <= sel33_f1_w & pin_i[0]; // R01
    end
  end
  // external interrupt three on pin 3.3
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      external_irq_three_in_o <= 1'b0;
    end else begin
      external_irq_three_in_o <= sel33_f2_w & pin_i[0]; // R01
    end
  end
  // external interrupt two on pin 3.4
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      external_irq_two_in_o <= 1'b0;
    end else begin
      external_irq_two_in_o <= sel34_f2_w & pin_i[1]; // R02
    end
  end
  // key wakeup two on pin 3.5
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      key_wakeup_two_in_o <= 1'b0;
    end else begin
      key_wakeup_two_in_o <= sel35_f2_w & pin_i[2]; // R03
    end
  end
  // converter start trigger on pin 3.7
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      converter_start_trigger_in_o <= 1'b0;
    end else begin
      converter_start_trigger_in_o <= sel37_f1_w & pin_i[3]; // R04
    end
  end
  // channel c capture only while the timer holds channel c as input
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      timer_c_channel_c_capture_o <= 1'b0;
    end else begin
      timer_c_channel_c_capture_o <= sel34_f1_w & ~tmr_q[`P3FS_TMR_CDIR] & pin_i[1]; // R06
    end
  end
  // channel d capture: pin 3.5 wins when both pins carry the function
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      timer_c_channel_d_capture_o <= 1'b0;
    end else if (sel35_f1_w & ~tmr_q[`P3FS_TMR_DDIR]) begin
      timer_c_channel_d_capture_o <= pin_i[2]; // R07
    end else if (sel37_f3_w & ~tmr_q[`P3FS_TMR_DDIR]) begin
      timer_c_channel_d_capture_o <= pin_i[3]; // R07
    end else begin
      timer_c_channel_d_capture_o <= 1'b0;
    end
  end
  // comparator inputs stay connected while their pins are gpio inputs
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      comparator_three_analog_en_o <= 1'b1;
    end else begin
      comparator_three_analog_en_o <= gpin_w[0]; // R10
    end
  end
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      comparator_three_reference_en_o <= 1'b1;
    end else begin
      comparator_three_reference_en_o <= gpin_w[1]; // R10
    end
  end
  // channel a pin drives the compare waveform only in the compare setting
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      timer_c_channel_a_pin_o <= 1'b0;
    end else begin
      timer_c_channel_a_pin_o <= chan_a_cmp_w & timer_c_channel_a_wave_i; // R08
    end
  end
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      timer_c_channel_a_pin_oe_n_o <= 1'b1;
    end else begin
      timer_c_channel_a_pin_oe_n_o <= ~chan_a_cmp_w; // R08
    end
  end
endmodule // p3fs_port3_function_select

// ---- p3fs_map.vh ----
// register offsets, field positions and reset values of the port 3 function select block
`ifndef P3FS_MAP_VH
`define P3FS_MAP_VH
`define P3FS_DIR_OFS 12'h000
`define P3FS_FSEL_OFS 12'h004
`define P3FS_TMR_OFS 12'h008
`define P3FS_PIN_OFS 12'h00c
`define P3FS_DIR_RST 4'h0
`define P3FS_FSEL_RST 8'h00
`define P3FS_TMR_RST 9'h000
`define P3FS_FLD33 1:0
`define P3FS_FLD34 3:2
`define P3FS_FLD35 5:4
`define P3FS_FLD37 7:6
`define P3FS_TMR_EA 0
`define P3FS_TMR_TWO_PHASE_PULSE_MODE_BIT 1
`define P3FS_TMR_IOA_LO 2
`define P3FS_TMR_EDGE_LO 5
`define P3FS_TMR_CDIR 7
`define P3FS_TMR_DDIR 8
`define P3FS_SEL_GPIO 2'h0
`define P3FS_SEL_F1 2'h1
`define P3FS_SEL_F2 2'h2
`define P3FS_SEL_F3 2'h3
`define P3FS_IOA_COMPARE 3'h1
`endif

// ---- p3fs_pin_cell.v ----
// one port 3 pin: function decode into a registered output value and output enable
`timescale 1ns/10ps
`include "p3fs_map.vh"
module p3fs_pin_cell (
  input wire clk_sys_i,
  input wire sys_rst_i,
  input wire [1:0] sel_i,
  input wire gpio_dir_i,
  input wire gpio_out_i,
  input wire [3:0] fn_dir_i,
  input wire [3:0] fn_out_i,
  output reg pin_o,
  output reg pin_oe_n_o,
  output reg is_gpio_in_o
);
  reg drv_d;
  reg val_d;
  always @* begin
    if (sel_i == `P3FS_SEL_GPIO) begin
      drv_d = gpio_dir_i;
      val_d = gpio_out_i;
    end else begin
      drv_d = fn_dir_i[sel_i];
      val_d = fn_out_i[sel_i];
    end
  end
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      pin_o <= 1'b0;
      pin_oe_n_o <= 1'b1;
      is_gpio_in_o <= 1'b1;
    end else begin
      pin_o <= val_d & drv_d;
      pin_oe_n_o <= ~drv_d;
      is_gpio_in_o <= (sel_i == `P3FS_SEL_GPIO) & ~gpio_dir_i;
    end
  end
endmodule // p3fs_pin_cell

// ---- p3fs_checker.sv ----
// concurrent checks on the port 3 function select ports
`timescale 1ns/10ps
module p3fs_checker (
  input wire clk_sys_i,
  input wire sys_rst_i,
  input wire psel_i,
  input wire penable_i,
  input wire pready_o,
  input wire pslverr_o,
  input wire [3:0] pin_i,
  input wire [3:0] pin_o,
  input wire [3:0] pin_oe_n_o,
  input wire timer_c_channel_a_wave_i,
  input wire timer_c_channel_a_pin_o,
  input wire timer_c_channel_a_pin_oe_n_o,
  input wire timer_c_external_clock_in_o,
  input wire external_irq_three_in_o,
  input wire key_wakeup_two_in_o,
  input wire comparator_three_analog_en_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  a_ready_cause: assert property (pready_o |-> $past(psel_i) && $past(penable_i))
    else $error("ready without access");
  a_err_ready: assert property (pslverr_o |-> pready_o) else $error("error without ready");
  a_clk_route: assert property (
    timer_c_external_clock_in_o |-> $past(pin_i[0]) && !external_irq_three_in_o)
    else $error("clock input misrouted");
  a_irq3_level: assert property (
    external_irq_three_in_o |-> $past(pin_i[0])) else $error("irq three level wrong");
  a_idle_low: assert property (!(|(pin_oe_n_o & pin_o))) else $error("undriven pin not 0");
  a_key_input: assert property (
    key_wakeup_two_in_o && $past(key_wakeup_two_in_o) |-> pin_oe_n_o[2])
    else $error("key wakeup pin driven");
  a_cha_wave: assert property (
    !timer_c_channel_a_pin_oe_n_o && $past(!timer_c_channel_a_pin_oe_n_o)
    |-> timer_c_channel_a_pin_o == $past(timer_c_channel_a_wave_i))
    else $error("channel a pin not wave");
  a_cmp_input: assert property (
    comparator_three_analog_en_o |-> $past(pin_oe_n_o[0]))
    else $error("comparator on driven pin");
endmodule // p3fs_checker
bind p3fs_port3_function_select p3fs_checker p3fs_checker_inst (.*);

// ---- p3fs_board.sv ----
// board model: resolves each port 3 pin level from device drive and board level
`timescale 1ns/10ps
module p3fs_board (
  input wire [3:0] dv_i,
  input wire [3:0] oe_n_i,
  input wire [3:0] ext_i,
  output wire [3:0] lvl_o
);
  // a driven pin reads back its own value, a released one the board level
  assign lvl_o = (oe_n_i & ext_i) | (~oe_n_i & dv_i);
endmodule // p3fs_board

// ---- p3fs_port3_function_select_tb.sv ----
// self-checking bench for the port 3 function select block
`timescale 1ns/10ps
module p3fs_port3_function_select_tb;
  logic clk_sys_i = 0, sys_rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, e;
  logic [11:0] paddr_i = 0;
  logic [31:0] pwdata_i = 0, r;
  logic [3:0] gpio_out_i = 0, ext_lvl = 0;
  logic timer_c_channel_a_wave_i = 1, timer_c_channel_c_wave_i = 1, timer_c_channel_d_wave_i = 1;
  logic comparator_three_out_i = 1, timer_j_pulse_out_i = 1;
  wire [31:0] prdata_o;
  wire [3:0] pin_i, pin_o, pin_oe_n_o, gpio_in_o;
  wire pready_o, pslverr_o, timer_c_channel_a_pin_o, timer_c_channel_a_pin_oe_n_o;
  wire timer_c_channel_c_capture_o, timer_c_channel_d_capture_o, timer_c_external_clock_in_o;
  wire external_irq_three_in_o, external_irq_two_in_o, key_wakeup_two_in_o;
  wire comparator_three_analog_en_o, comparator_three_reference_en_o, converter_start_trigger_in_o;
  wire [1:0] cmp = {comparator_three_analog_en_o, comparator_three_reference_en_o};
  wire [14:0] pv = {pin_oe_n_o, pin_o, timer_c_external_clock_in_o, timer_c_channel_c_capture_o,
    timer_c_channel_d_capture_o, converter_start_trigger_in_o, external_irq_three_in_o,
    external_irq_two_in_o, key_wakeup_two_in_o};
  logic [14:0] exp_t [1:3] = '{15'h7878, 15'h3c07, 15'h5a10};
  int err_count = 0, samples_checked = 0, cyc = 0;
  p3fs_port3_function_select p3fs_port3_function_select_inst (.*);
  p3fs_board p3fs_board_inst (.dv_i(pin_o), .oe_n_i(pin_oe_n_o), .ext_i(ext_lvl), .lvl_o(pin_i));
  always #10 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      results();
    end
  end
  task results;
    if (err_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, x);
    samples_checked++;
    if (s !== x) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, x, s);
    end
  endtask
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1;
    do @(posedge clk_sys_i); while (pready_o !== 1);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1, a, d);
    chk("wr_err", e, 0);
    repeat (3) @(posedge clk_sys_i);
  endtask
  initial begin
    repeat (4) @(posedge clk_sys_i);
    sys_rst_i <= 0;
    chk("cmp_rst", cmp, 3);
    for (int i = 0; i < 4; i++) begin
      xfer(0, 12'(i * 4), 0);
      chk("rst_rd", {e, r[30:0]}, 0);
    end
    xfer(0, 12'h010, 0);
    chk("unmapped", {|r, e}, 1);
    xfer(1, 12'h00c, 32'hf);
    chk("pin_wr", e, 1);
    gpio_out_i <= 4'h5;
    wr(12'h000, 32'hf);
    chk("gpio_out", {pin_oe_n_o, pin_o}, 8'h05);
    chk("cmp_off", cmp, 0);
    ext_lvl <= 4'ha;
    wr(12'h000, 0);
    chk("gpio_in", {pin_oe_n_o, gpio_in_o}, 8'hfa);
    chk("cmp_on", cmp, 3);
    ext_lvl <= 4'hf;
    wr(12'h000, 32'hf);
    for (int s = 1; s < 4; s++) begin
      wr(12'h004, {24'h0, {4{2'(s)}}});
      chk("fn_sel", pv, exp_t[s]);
    end
    timer_c_channel_d_wave_i <= 0;
    wr(12'h008, 32'h180);
    wr(12'h004, 32'h55);
    chk("chc_out", {pin_oe_n_o, pin_o}, 8'h92);
    gpio_out_i <= 0;
    timer_c_channel_c_wave_i <= 0;
    timer_c_channel_d_wave_i <= 1;
    wr(12'h004, 32'hc5);
    chk("chd_out", {pin_oe_n_o, pin_o}, 8'h18);
    wr(12'h008, 32'h003);
    wr(12'h008, 32'h067);
    chk("cha_hold", timer_c_channel_a_pin_oe_n_o, 1);
    wr(12'h008, 32'h066);
    chk("cha_on", {timer_c_channel_a_pin_oe_n_o, timer_c_channel_a_pin_o}, 1);
    xfer(0, 12'h008, 0);
    chk("tmr_rd", r, 32'h066);
    timer_c_channel_a_wave_i <= 0;
    repeat (2) @(posedge clk_sys_i);
    chk("cha_wave", {timer_c_channel_a_pin_oe_n_o, timer_c_channel_a_pin_o}, 0);
    wr(12'h008, 32'h067);
    chk("cha_off", timer_c_channel_a_pin_oe_n_o, 1);
    results();
  end
endmodule // p3fs_port3_function_select_tb
